/* rtl/watchdog_timer_control.sv */
// watchdog control and status register, time-out counter and action logic
`timescale 1ns/1ps
module watchdog_timer_control #(
  parameter int BASE_LOG2 = wdt_ctrl_pkg::BASE_TIMEOUT_LOG2,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_pin,
  input wire logic watchdog_restart,
  input wire logic irq_vector_ack,
  input wire logic global_irq_enable,
  input wire logic always_on_fuse,
  input wire logic watchdog_reset_flag,
  output logic timeout_irq_request,
  output logic system_reset_request
);

  localparam int CW = wdt_ctrl_pkg::COUNT_WIDTH;

  typedef struct packed {
    logic timeout_irq_flag;
    logic timeout_irq_enable;
    logic system_reset_enable;
    logic change_enable;
    logic [3:0] timeout_prescale_select;
    logic [2:0] chg_cnt;
    logic [CW-1:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_req;
    logic sys_rst;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic tick;
  logic fuse_prog;
  logic rst_eff;
  logic ie_eff;
  logic stopped;
  logic timeout;
  logic hit;
  logic commit;
  logic set_flag;
  logic do_reset;
  logic [7:0] wbyte;
  logic [7:0] csr_view;

  // terminal count for a prescaler code; reserved codes fall back to code 0
  function automatic logic [CW-1:0] terminal(input logic [3:0] code);
    logic [CW:0] len;
    len = '0;
    if (code <= wdt_ctrl_pkg::LAST_LONG_CODE) begin
      len = (CW+1)'(1) << (BASE_LOG2 + int'(code));
    end else if (code <= wdt_ctrl_pkg::LAST_SHORT_CODE) begin
      len = (CW+1)'(1) << (BASE_LOG2 + 9 - int'(code));
    end else begin
      len = (CW+1)'(1) << BASE_LOG2;
    end
    return CW'(len - (CW+1)'(1));
  endfunction

  osc_edge_detect u_osc (
    .clock(clock),
    .srst(srst),
    .osc_in(osc_pin),
    .tick(tick)
  );

  // effective mode bits after the fuse and reset-flag overrides
  assign fuse_prog = ~always_on_fuse;
  assign rst_eff = fuse_prog | s_r.system_reset_enable | watchdog_reset_flag;
  assign ie_eff = ~fuse_prog & s_r.timeout_irq_enable;
  assign stopped = ~rst_eff & ~ie_eff;
  // >= rather than == so a shorter period fires at once instead of wrapping
  assign timeout = tick & ~stopped & (s_r.count >= terminal(s_r.timeout_prescale_select));

  // apb decode; a write lands on the edge where pready is seen high
  assign hit = (paddr == ADDR_W'(wdt_ctrl_pkg::CSR_OFFSET));
  assign commit = psel & penable & s_r.pready & pwrite & hit;
  assign wbyte = pwdata[7:0];

  // interrupt in interrupt modes unless a combined-mode flag is still pending
  assign set_flag = timeout & ie_eff & ~(rst_eff & s_r.timeout_irq_flag);
  assign do_reset = timeout & rst_eff & (~ie_eff | s_r.timeout_irq_flag);

  // read view shows effective enables, not the stored ones
  always_comb begin
    csr_view = '0;
    csr_view[wdt_ctrl_pkg::FLAG_BIT] = s_r.timeout_irq_flag;
    csr_view[wdt_ctrl_pkg::IRQ_EN_BIT] = ie_eff;
    csr_view[wdt_ctrl_pkg::PRESC_HI_BIT] = s_r.timeout_prescale_select[3];
    csr_view[wdt_ctrl_pkg::CHG_EN_BIT] = s_r.change_enable;
    csr_view[wdt_ctrl_pkg::RST_EN_BIT] = rst_eff;
    csr_view[wdt_ctrl_pkg::PRESC_LO_MSB:0] = s_r.timeout_prescale_select[2:0];
  end

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // counter: held at zero while stopped, cleared by restart and after each time-out
    if (stopped || watchdog_restart || timeout) begin
      s_nxt.count = '0;
    end else if (tick) begin
      s_nxt.count = s_r.count + CW'(1);
    end
    // change enable window
    if (s_r.change_enable) begin
      if (s_r.chg_cnt <= 3'h1) begin
        s_nxt.change_enable = 1'b0;
        s_nxt.chg_cnt = '0;
      end else begin
        s_nxt.chg_cnt = s_r.chg_cnt - 3'h1;
      end
    end
    if (commit) begin
      if (wbyte[wdt_ctrl_pkg::FLAG_BIT]) begin
        s_nxt.timeout_irq_flag = 1'b0;
      end
      s_nxt.timeout_irq_enable = wbyte[wdt_ctrl_pkg::IRQ_EN_BIT];
      // setting reset enable is free, clearing it needs the open window
      if (wbyte[wdt_ctrl_pkg::RST_EN_BIT]) begin
        s_nxt.system_reset_enable = 1'b1;
      end else if (s_r.change_enable) begin
        s_nxt.system_reset_enable = 1'b0;
      end
      if (s_r.change_enable) begin
        s_nxt.timeout_prescale_select = {wbyte[wdt_ctrl_pkg::PRESC_HI_BIT],
                                         wbyte[wdt_ctrl_pkg::PRESC_LO_MSB:0]};
      end
      if (wbyte[wdt_ctrl_pkg::CHG_EN_BIT]) begin
        s_nxt.change_enable = 1'b1;
        s_nxt.chg_cnt = wdt_ctrl_pkg::CHG_WINDOW_CYCLES;
      end
    end
    // vector execution clears the flag, and in combined mode the enable too
    if (irq_vector_ack) begin
      s_nxt.timeout_irq_flag = 1'b0;
      if (rst_eff) begin
        s_nxt.timeout_irq_enable = 1'b0;
      end
    end
    // a time-out in the same cycle as a clear still sets the flag
    if (set_flag) begin
      s_nxt.timeout_irq_flag = 1'b1;
    end
    s_nxt.sys_rst = do_reset;
    s_nxt.irq_req = s_nxt.timeout_irq_flag & ~fuse_prog & s_nxt.timeout_irq_enable
                    & global_irq_enable;
    // apb answer: one wait state, read data captured with pready
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~hit;
      s_nxt.prdata = (hit && !pwrite) ? {24'h0, csr_view} : 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.timeout_irq_flag <= wdt_ctrl_pkg::CSR_RESET_VALUE[wdt_ctrl_pkg::FLAG_BIT];
      s_r.timeout_irq_enable <= wdt_ctrl_pkg::CSR_RESET_VALUE[wdt_ctrl_pkg::IRQ_EN_BIT];
      s_r.system_reset_enable <= wdt_ctrl_pkg::CSR_RESET_VALUE[wdt_ctrl_pkg::RST_EN_BIT];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign timeout_irq_request = s_r.irq_req;
  assign system_reset_request = s_r.sys_rst;

  // checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence write_chg_s;
    commit && pwdata[wdt_ctrl_pkg::CHG_EN_BIT];
  endsequence

  sequence quiet4_s;
    (!commit)[*4];
  endsequence

  sequence combined_timeout_s;
    timeout && rst_eff && ie_eff;
  endsequence

  irq_only_flag_a: assert property (
    (timeout && ie_eff && !rst_eff) |=> s_r.timeout_irq_flag)
    else $error("interrupt-only time-out did not set the flag");

  vector_clear_a: assert property (
    (irq_vector_ack && !timeout) |=> !s_r.timeout_irq_flag)
    else $error("vector execution left the flag set");

  flag_w1c_a: assert property (
    (commit && pwdata[wdt_ctrl_pkg::FLAG_BIT] && !timeout && s_r.timeout_irq_flag)
    |=> !s_r.timeout_irq_flag)
    else $error("write one did not clear the flag");

  flag_w0_keep_a: assert property (
    (commit && !pwdata[wdt_ctrl_pkg::FLAG_BIT] && !irq_vector_ack && s_r.timeout_irq_flag)
    |=> s_r.timeout_irq_flag)
    else $error("write zero changed the flag");

  irq_gate_a: assert property (
    timeout_irq_request |-> s_r.timeout_irq_flag && ie_eff && $past(global_irq_enable))
    else $error("interrupt requested without flag and enables");

  stopped_count_a: assert property (
    (stopped && !commit) |=> s_r.count == '0 && !system_reset_request)
    else $error("stopped watchdog counted or reset");

  reset_mode_a: assert property (
    (timeout && rst_eff && !ie_eff) |=> system_reset_request && !$rose(s_r.timeout_irq_flag))
    else $error("reset mode time-out did not reset");

  combined_first_a: assert property (
    (combined_timeout_s and !s_r.timeout_irq_flag) |=> !system_reset_request
    && s_r.timeout_irq_flag)
    else $error("combined mode first time-out wrong");

  combined_ack_a: assert property (
    (irq_vector_ack && rst_eff && !commit) |=> !s_r.timeout_irq_enable)
    else $error("combined mode vector did not drop the enable");

  combined_second_a: assert property (
    (combined_timeout_s and s_r.timeout_irq_flag) |=> system_reset_request)
    else $error("pending flag at time-out did not reset");

  fuse_reset_a: assert property (
    (timeout && !always_on_fuse) |=> system_reset_request && !timeout_irq_request)
    else $error("programmed fuse did not force reset mode");

  presc_lock_a: assert property (
    (commit && !s_r.change_enable) |=> $stable(s_r.timeout_prescale_select))
    else $error("prescaler changed outside the window");

  chg_window_a: assert property (
    write_chg_s |=> s_r.change_enable[*4])
    else $error("change enable did not hold four cycles");

  chg_close_a: assert property (
    write_chg_s ##1 quiet4_s |=> !s_r.change_enable)
    else $error("change enable did not clear after four cycles");

  rst_flag_force_a: assert property (
    (timeout && watchdog_reset_flag && !ie_eff) |=> system_reset_request)
    else $error("reset flag did not force reset enable");

  restart_a: assert property (
    (watchdog_restart && !stopped) |=> s_r.count == '0)
    else $error("restart did not clear the count");

  recur_a: assert property (
    timeout |=> s_r.count == '0 ##1 s_r.count <= CW'(1))
    else $error("count did not restart after time-out");

  // a read answer being registered this cycle
  sequence read_answer_s;
    psel && penable && !s_r.pready && hit && !pwrite;
  endsequence

  irq_only_no_reset_a: assert property (
    (timeout && ie_eff && !rst_eff) |=> !system_reset_request)
    else $error("interrupt-only time-out gave a reset");

  irq_global_a: assert property (
    !global_irq_enable |=> !timeout_irq_request)
    else $error("interrupt requested with global enable off");

  rst_en_lock_a: assert property (
    (commit && !s_r.change_enable && s_r.system_reset_enable) |=> s_r.system_reset_enable)
    else $error("reset enable cleared outside the window");

  fuse_view_a: assert property (
    (read_answer_s and !always_on_fuse) |=> prdata[wdt_ctrl_pkg::RST_EN_BIT]
    && !prdata[wdt_ctrl_pkg::IRQ_EN_BIT])
    else $error("programmed fuse did not lock the enables");

  // terminal counts written out independently of the decode function
  long_code_a: assert property (
    (tick && !stopped && s_r.timeout_prescale_select == 4'h9
     && s_r.count == CW'((1 << (BASE_LOG2 + 9)) - 1)) |-> timeout)
    else $error("longest code missed its terminal count");

  early_code_a: assert property (
    (tick && s_r.timeout_prescale_select == 4'h0
     && s_r.count < CW'((1 << BASE_LOG2) - 1)) |-> !timeout)
    else $error("code zero timed out early");

  short_code_a: assert property (
    (tick && !stopped && s_r.timeout_prescale_select == 4'hd
     && s_r.count == CW'((1 << (BASE_LOG2 - 4)) - 1)) |-> timeout)
    else $error("shortest code missed its terminal count");

endmodule

/* rtl/wdt_ctrl_pkg.sv */
// constants used by the watchdog control block, not by its oscillator edge detector
package wdt_ctrl_pkg;

  // register map
  localparam logic [7:0] CSR_OFFSET = 8'h00;
  localparam logic [7:0] CSR_RESET_VALUE = 8'h00;

  // field positions within the control and status byte
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int PRESC_HI_BIT = 5;
  localparam int CHG_EN_BIT = 4;
  localparam int RST_EN_BIT = 3;
  localparam int PRESC_LO_MSB = 2;

  // change enable window in clock cycles
  localparam logic [2:0] CHG_WINDOW_CYCLES = 3'h4;

  // time-out lengths: log2 of the code 0 length and code landmarks
  localparam int BASE_TIMEOUT_LOG2 = 11;
  localparam logic [3:0] LAST_LONG_CODE = 4'h9;
  localparam logic [3:0] LAST_SHORT_CODE = 4'hd;
  localparam int COUNT_WIDTH = 21;

endpackage

/* rtl/osc_edge_detect.sv */
// synchroniser and rising edge detector for the watchdog oscillator pin
`timescale 1ns/1ps
module osc_edge_detect (
  input wire logic clock,
  input wire logic srst,
  input wire logic osc_in,
  output logic tick
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic tick;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // meta feeds only sync; the edge is taken between sync and last
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = osc_in;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
    s_nxt.tick = s_r.sync & ~s_r.last;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

/* bench/watchdog_timer_control_tb_top.sv */
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
module watchdog_timer_control_tb_top;
  typedef struct {logic [7:0] wd; logic [7:0] exp;} row_s;
  typedef struct {logic [3:0] code; int ticks;} code_s;
  localparam int BASE = 4; // short time-outs keep the run brief
  localparam int TICK = 10; // clock cycles per oscillator period
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_pin = 1'b0;
  logic watchdog_restart = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic global_irq_enable = 1'b1;
  logic always_on_fuse = 1'b1;
  logic watchdog_reset_flag = 1'b0;
  logic timeout_irq_request;
  logic system_reset_request;
  int mismatches = 0;
  int tests_run = 0;
  int rst_cnt = 0;
  int n;
  int r0;
  logic [31:0] rdata;
  logic rerr;
  // register writes applied in order, with the byte read back after each
  row_s rows [5] = '{'{8'h40, 8'h40}, '{8'h47, 8'h40}, '{8'h48, 8'h48},
    '{8'h00, 8'h08}, '{8'h80, 8'h08}};
  // codes with their time-out length in oscillator ticks for BASE = 4
  code_s codes [5] = '{'{4'hd, 1}, '{4'ha, 8}, '{4'h1, 32}, '{4'he, 16}, '{4'h0, 16}};

  watchdog_timer_control #(.BASE_LOG2(BASE), .ADDR_W(8)) watchdog_timer_control_i (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin(osc_pin), .watchdog_restart(watchdog_restart),
    .irq_vector_ack(irq_vector_ack), .global_irq_enable(global_irq_enable),
    .always_on_fuse(always_on_fuse), .watchdog_reset_flag(watchdog_reset_flag),
    .timeout_irq_request(timeout_irq_request), .system_reset_request(system_reset_request));

  always #5 clock = ~clock;
  // oscillator far faster than real so time-outs stay short
  always begin
    repeat (5) @(posedge clock);
    osc_pin <= ~osc_pin;
  end
  // reset pulses are one cycle wide, so count them as they pass
  always @(posedge clock) if (system_reset_request === 1'b1) rst_cnt <= rst_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; hold keeps psel up for a back-to-back follower
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit hold);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    check(pready, 1'b1);
    rdata = prdata;
    rerr = pslverr;
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic wr(input logic [7:0] d, input bit hold);
    apb(1'b1, 8'h00, {24'h0, d}, hold);
  endtask

  task automatic rd();
    apb(1'b0, 8'h00, 32'h0, 1'b0);
  endtask

  // timed sequence: open the window, then the real write right behind it
  task automatic set_mode(input logic [7:0] v);
    wr(8'h18, 1'b1);
    wr(v, 1'b0);
  endtask

  task automatic pulse_ack();
    irq_vector_ack <= 1'b1;
    @(posedge clock);
    irq_vector_ack <= 1'b0;
    @(posedge clock);
  endtask

  task automatic pulse_restart();
    watchdog_restart <= 1'b1;
    @(posedge clock);
    watchdog_restart <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    while (timeout_irq_request !== 1'b1 && c < 2000) begin
      @(posedge clock);
      c++;
    end
  endtask

  task automatic wait_rst(output int c);
    int c0;
    c0 = rst_cnt;
    c = 0;
    while (rst_cnt == c0 && c < 2000) begin
      @(posedge clock);
      c++;
    end
  endtask

  function automatic logic [7:0] pb(input logic [3:0] c);
    return {2'b00, c[3], 2'b00, c[2:0]};
  endfunction

  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd();
    check(rdata, 32'h0);
    check(rerr, 1'b0);
    // unmapped place refuses and stores nothing
    apb(1'b1, 8'h04, 32'h40, 1'b0);
    check(rerr, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].wd, 1'b0);
      rd();
      check(rdata, {24'h0, rows[i].exp});
    end
    wait_rst(n);
    check(n <= 175, 1'b1);
    set_mode(8'h00);
    rd();
    check(rdata, 32'h0);
    n = rst_cnt;
    repeat (400) @(posedge clock);
    check({rst_cnt == n, timeout_irq_request}, 2'b10);
    // window left to expire before the clearing write
    wr(8'h18, 1'b0);
    repeat (2) @(posedge clock);
    wr(8'h00, 1'b0);
    rd();
    check(rdata, 32'h08);
    set_mode(8'h00);
    // restart first so a shorter period cannot fire at once
    foreach (codes[i]) begin
      pulse_restart();
      set_mode(8'h40 | pb(codes[i].code));
      pulse_ack();
      pulse_restart();
      wait_irq(n);
      check(n >= (codes[i].ticks - 1) * TICK, 1'b1);
      check(n <= codes[i].ticks * TICK + 1, 1'b1);
    end
    // combined mode: interrupt, re-arm, interrupt, then reset when left pending
    pulse_restart();
    set_mode(8'hc8 | pb(4'ha));
    r0 = rst_cnt;
    wait_irq(n);
    check({n <= 8 * TICK + 1, rst_cnt == r0}, 2'b11);
    pulse_ack();
    rd();
    check(rdata, 32'h2a);
    wr(8'h6a, 1'b0);
    wait_irq(n);
    check({n <= 8 * TICK + 1, rst_cnt == r0}, 2'b11);
    wait_rst(n);
    check(n <= 8 * TICK + 2, 1'b1);
    // reset flag keeps reset enable on until it is cleared first
    pulse_restart();
    watchdog_reset_flag <= 1'b1;
    set_mode(8'h80);
    rd();
    check(rdata, 32'h08);
    wait_rst(n);
    check(n <= 16 * TICK + 2, 1'b1);
    watchdog_reset_flag <= 1'b0;
    set_mode(8'h00);
    rd();
    check(rdata, 32'h0);
    // mid-run reset out of a running interrupt mode
    wr(8'h40, 1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check({timeout_irq_request, system_reset_request}, 2'b00);
    rd();
    check(rdata, 32'h0);
    // programmed fuse: reset mode whatever the enables hold
    always_on_fuse <= 1'b0;
    wr(8'h40, 1'b0);
    rd();
    check(rdata, 32'h08);
    wait_rst(n);
    check({n <= 16 * TICK + 2, timeout_irq_request}, 2'b10);
    close_out();
  end
endmodule
